// >>> design/plcc_pkg.sv
// constants shared by the clock controller and the core-side sequencer
// assumes one 40 MHz ref_clk (main oscillator domain) for both ends
// Overview of operation
// RULE1: crystal value change starts PLL relock
// RULE2: PLL power-up starts a relock period
// RULE3: relock down counter loads 0x1200 each trigger
// RULE4: PLL unusable as source until counter expires
// RULE5: combined enable/select waits on oscillator
// RULE6: lock reported in raw status, optional interrupt
// RULE7: run mode clocks core, run-gated peripherals
// RULE8: sleep stops core and memory clocks
// RULE9: sleep gating from sleep set if auto
// RULE10: sleep keeps run source and frequency
// RULE11: deep sleep stops core, uses deep set
// RULE12: deep sleep main osc or chosen internal
// RULE13: deep sleep powers PLL down, clamps divider
// RULE14: wake restores clock before re-enabling clocks
// RULE15: core sets deep enable before wait instruction
// RULE16: second config overrides first when enabled
// RULE17: software PLL change follows five ordered steps
// RULE18: crystal write loads PLL translation automatically
// RULE19: power-off bit disables PLL output
// RULE20: stable reference before switching to PLL
// RULE21: PLL output halved, then divided by code+1
// RULE22: powered-down PLL drives no output
// RULE23: lock flag set at zero, cleared on relock
// RULE24: source switches are glitch free
package plcc_pkg;
	localparam int PLCC_AW = 4;
	localparam int PLCC_DW = 32;
	localparam logic [3:0] REG_RUN_CLOCK_CONFIG = 4'h0;
	localparam logic [3:0] REG_RUN_CLOCK_CONFIG_SECOND = 4'h1;
	localparam logic [3:0] REG_RAW_IRQ_STATUS = 4'h2;
	localparam logic [3:0] REG_IRQ_MASK = 4'h3;
	localparam logic [3:0] REG_PLL_XLATE = 4'h4;
	localparam logic [3:0] REG_RUN_GATE = 4'h5;
	localparam logic [3:0] REG_SLEEP_GATE = 4'h6;
	localparam logic [3:0] REG_DEEP_SLEEP_GATE = 4'h7;
	localparam logic [3:0] REG_DEEP_SLEEP_CLOCK_CFG = 4'h8;
	localparam logic [3:0] REG_CLOCK_STATE = 4'h9;
	// field positions
	localparam int OSC_LO = 4;
	localparam int CRYSTAL_SELECT_LO = 6;
	localparam int BYPASS_BIT = 11;
	localparam int PWROFF_BIT = 13;
	localparam int APPLY_BIT = 22;
	localparam int DIV_LO = 23;
	localparam int AUTOGATE_BIT = 27;
	localparam int OVR_BIT = 31;
	localparam int LOCK_BIT = 6;
	// reset values
	localparam logic [31:0] RCC_RST = 32'h07803AD1;
	localparam logic [31:0] RUN_CLOCK_CONFIG_SECOND_RST = 32'h07802810;
	localparam logic [31:0] DSCFG_RST = 32'h07800000;
	localparam logic [31:0] GATE_RST = 32'h00000040;
	// oscillator codes
	localparam logic [2:0] OSC_MAIN = 3'h0;
	localparam logic [2:0] OSC_INT = 3'h1;
	localparam logic [2:0] OSC_INT4 = 3'h2;
	localparam logic [5:0] DS_DIV_MAX1 = 6'h0F;
	localparam logic [5:0] DS_DIV_MAX2 = 6'h3F;
	// timing
	localparam logic [15:0] RELOCK_COUNT = 16'h1200;
	localparam logic [1:0] SWITCH_GAP = 2'h2;
	localparam logic [15:0] PLL_XLATE_BASE = 16'h0100;
	// host command bits
	localparam int CMD_WR = 0;
	localparam int CMD_RD = 1;
	localparam int CMD_WFI = 2;
	localparam int CMD_WAKE = 3;
	localparam int CMD_PLL = 4;
	localparam logic [3:0] H_TARGET = 4'h0;
	localparam logic [3:0] H_DATA = 4'h1;
	localparam logic [3:0] H_CMD = 4'h2;
	localparam logic [3:0] H_DEEP = 4'h3;
	localparam logic [3:0] H_PLL = 4'h4;
	localparam logic [3:0] H_STAT = 4'h5;
	typedef enum logic [1:0] {
		PLCC_RUN = 2'b00,
		PLCC_SLEEP = 2'b01,
		PLCC_DEEP = 2'b10,
		PLCC_WAKE = 2'b11
	} plcc_mode_t;
	function automatic logic [15:0] plcc_xlate(input logic [3:0] crystal_select);
		plcc_xlate = PLL_XLATE_BASE | {8'h00, crystal_select, 4'h0};
	endfunction : plcc_xlate
endpackage : plcc_pkg

// >>> design/plcc_if.sv
// register bus and sleep signalling between processor core and clock controller
// assumes both ends sit on the same ref_clk
`timescale 1ns/1ps
interface plcc_if;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic wr;
	logic rd;
	logic wait_for_interrupt_instr;
	logic deep_en;
	logic wake;
	logic lock_irq;
	modport dev(input addr, wdata, wr, rd, wait_for_interrupt_instr, deep_en, wake, output rdata, lock_irq);
	modport core(output addr, wdata, wr, rd, wait_for_interrupt_instr, deep_en, wake, input rdata, lock_irq);
endinterface : plcc_if

// >>> design/plcc_clock_ctrl.sv
// clock controller: PLL relock timing, source switching, mode gating
// assumes ref_clk is the main oscillator and the core obeys the bus strobes
`timescale 1ns/1ps
module plcc_clock_ctrl import plcc_pkg::*; #(
	parameter int NP = 32,
	parameter logic [15:0] RELOCK_CYC = RELOCK_COUNT
) (
	input wire logic ref_clk,
	input wire logic rst,
	plcc_if.dev bus,
	output logic cpu_clk_en,
	output logic mem_clk_en,
	output logic [NP-1:0] periph_clk_en,
	output logic sys_clk_run,
	output logic [2:0] sys_src,
	output logic pll_sel,
	output logic pll_prediv,
	output logic [5:0] sys_div,
	output logic div_en,
	output logic pll_pwr,
	output logic mosc_pwr,
	output logic int_osc_pwr,
	output logic [15:0] pll_cfg,
	output plcc_mode_t mode
);
	logic [31:0] run_clock_config, run_clock_config_second, ds_cfg, imask;
	logic [NP-1:0] run_g, slp_g, dp_g;
	logic [15:0] relock_cnt;
	logic lock_raw, pll_run_q, ds_was_pll;
	logic [1:0] sw_cnt;
	logic ovr, e_pwroff, e_bypass, apply, autogate, pll_run, pll_ready, crystal_select_chg, trig;
	logic [2:0] e_osc, ds_osc, t_src;
	logic [5:0] e_div, ds_div, ds_max, t_div;
	logic t_pll, t_div_en, mismatch, restored;
	logic [NP-1:0] gate_sel;
	logic [31:0] rmux;

	// RULE16: the second register wins only while its override bit is set
	always_comb begin
		ovr = run_clock_config_second[OVR_BIT];
		e_pwroff = ovr ? run_clock_config_second[PWROFF_BIT] : run_clock_config[PWROFF_BIT]; // RULE16
		e_bypass = ovr ? run_clock_config_second[BYPASS_BIT] : run_clock_config[BYPASS_BIT];
		e_osc = ovr ? run_clock_config_second[OSC_LO+:3] : {1'b0, run_clock_config[OSC_LO+:2]};
		e_div = ovr ? run_clock_config_second[DIV_LO+:6] : {2'b00, run_clock_config[DIV_LO+:4]};
		apply = run_clock_config[APPLY_BIT];
		autogate = run_clock_config[AUTOGATE_BIT];
		ds_osc = ds_cfg[OSC_LO+:3];
		ds_div = ds_cfg[DIV_LO+:6];
	end

	// PLL power: off bit, or forced off for the deep sleep it was running into
	assign pll_run = !e_pwroff && !(mode == PLCC_DEEP && ds_was_pll); // RULE19 RULE13
	assign crystal_select_chg = bus.wr && bus.addr == REG_RUN_CLOCK_CONFIG
		&& bus.wdata[CRYSTAL_SELECT_LO+:4] != run_clock_config[CRYSTAL_SELECT_LO+:4]; // RULE1
	assign trig = crystal_select_chg || (pll_run && !pll_run_q); // RULE1 RULE2
	assign pll_ready = lock_raw && pll_run && relock_cnt == 16'h0000; // RULE4

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			run_clock_config <= RCC_RST;
			run_clock_config_second <= RUN_CLOCK_CONFIG_SECOND_RST;
			ds_cfg <= DSCFG_RST;
			imask <= 32'h00000000;
			run_g <= GATE_RST[NP-1:0];
			slp_g <= GATE_RST[NP-1:0];
			dp_g <= GATE_RST[NP-1:0];
		end else if (bus.wr) begin
			case (bus.addr)
				REG_RUN_CLOCK_CONFIG: run_clock_config <= bus.wdata;
				REG_RUN_CLOCK_CONFIG_SECOND: run_clock_config_second <= bus.wdata;
				REG_IRQ_MASK: imask <= bus.wdata & (32'h00000001 << LOCK_BIT);
				REG_RUN_GATE: run_g <= bus.wdata[NP-1:0];
				REG_SLEEP_GATE: slp_g <= bus.wdata[NP-1:0];
				REG_DEEP_SLEEP_GATE: dp_g <= bus.wdata[NP-1:0];
				REG_DEEP_SLEEP_CLOCK_CFG: ds_cfg <= bus.wdata;
				default: ;
			endcase
		end
	end

	// translation follows every crystal write with no extra step
	always_ff @(posedge ref_clk) begin
		if (rst)
			pll_cfg <= 16'h0000;
		else if (bus.wr && bus.addr == REG_RUN_CLOCK_CONFIG)
			pll_cfg <= plcc_xlate(bus.wdata[CRYSTAL_SELECT_LO+:4]); // RULE18
		else
			pll_cfg <= plcc_xlate(run_clock_config[CRYSTAL_SELECT_LO+:4]); // RULE18
	end

	// relock timer; a new trigger clears the flag, expiry sets it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			relock_cnt <= 16'h0000;
			lock_raw <= 1'b0;
			pll_run_q <= 1'b0;
		end else begin
			pll_run_q <= pll_run;
			if (trig) begin
				relock_cnt <= RELOCK_CYC; // RULE3
				lock_raw <= 1'b0; // RULE23
			end else if (relock_cnt != 16'h0000) begin
				relock_cnt <= relock_cnt - 16'h0001; // RULE3
				if (relock_cnt == 16'h0001)
					lock_raw <= 1'b1; // RULE23 RULE6
			end
		end
	end

	// target clock: deep sleep has its own source, and its own divider only if the PLL was running when it was entered; all else the run setup
	always_comb begin
		ds_max = ovr ? DS_DIV_MAX2 : DS_DIV_MAX1;
		if (mode == PLCC_DEEP) begin
			t_src = ds_osc; // RULE12
			t_pll = 1'b0; // RULE13
			t_div = e_div;
			t_div_en = apply;
			if (ds_was_pll) begin
				t_div = ds_div > ds_max ? ds_max : ds_div; // RULE13
				t_div_en = 1'b1;
			end
		end else begin
			t_src = e_osc; // RULE10
			t_pll = !e_bypass && pll_ready; // RULE4 RULE5
			t_div = e_div;
			t_div_en = apply || t_pll; // RULE21
		end
		mismatch = t_src != sys_src || t_pll != pll_sel || t_div != sys_div
			|| t_div_en != div_en;
	end

	// the clock is held stopped across a change so no short pulse escapes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sw_cnt <= 2'h0;
			sys_clk_run <= 1'b0;
			sys_src <= OSC_MAIN;
			pll_sel <= 1'b0;
			pll_prediv <= 1'b0;
			sys_div <= 6'h00;
			div_en <= 1'b0;
		end else if (sw_cnt != 2'h0) begin
			sw_cnt <= sw_cnt - 2'h1;
			sys_clk_run <= 1'b0; // RULE24
			if (sw_cnt == 2'h1) begin
				sys_src <= t_src;
				pll_sel <= t_pll;
				pll_prediv <= t_pll; // RULE21
				sys_div <= t_div;
				div_en <= t_div_en;
			end
		end else if (mismatch) begin
			sw_cnt <= SWITCH_GAP; // RULE24
			sys_clk_run <= 1'b0;
		end else begin
			sys_clk_run <= 1'b1;
		end
	end

	assign restored = sw_cnt == 2'h0 && !mismatch && sys_clk_run
		&& (!ds_was_pll || pll_sel);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode <= PLCC_RUN;
			ds_was_pll <= 1'b0;
		end else begin
			case (mode)
				PLCC_RUN: begin
					if (bus.wait_for_interrupt_instr) begin
						mode <= bus.deep_en ? PLCC_DEEP : PLCC_SLEEP; // RULE8 RULE15
						ds_was_pll <= bus.deep_en && pll_run; // RULE13
					end
				end
				PLCC_SLEEP: if (bus.wake) mode <= PLCC_RUN;
				PLCC_DEEP: if (bus.wake) mode <= PLCC_WAKE;
				PLCC_WAKE: begin
					if (restored) begin
						mode <= PLCC_RUN; // RULE14
						ds_was_pll <= 1'b0;
					end
				end
				default: mode <= PLCC_RUN;
			endcase
		end
	end

	// stopped clocks stay stopped through the wake restore
	always_comb begin
		case (mode)
			PLCC_RUN: gate_sel = run_g; // RULE7
			PLCC_SLEEP: gate_sel = autogate ? slp_g : run_g; // RULE9
			default: gate_sel = autogate ? dp_g : run_g; // RULE11 RULE14
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cpu_clk_en <= 1'b0;
			mem_clk_en <= 1'b0;
			pll_pwr <= 1'b0;
			mosc_pwr <= 1'b1;
			int_osc_pwr <= 1'b1;
		end else begin
			cpu_clk_en <= mode == PLCC_RUN && sys_clk_run; // RULE7 RULE8 RULE11
			mem_clk_en <= mode == PLCC_RUN && sys_clk_run; // RULE8 RULE11
			pll_pwr <= pll_run; // RULE19 RULE22
			mosc_pwr <= !(mode == PLCC_DEEP && ds_osc != OSC_MAIN); // RULE12
			int_osc_pwr <= e_osc == OSC_INT || e_osc == OSC_INT4
				|| (mode == PLCC_DEEP && ds_osc != OSC_MAIN); // RULE12
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_gate
			always_ff @(posedge ref_clk) begin
				if (rst)
					periph_clk_en[gi] <= 1'b0;
				else
					periph_clk_en[gi] <= sys_clk_run && gate_sel[gi]; // RULE7
			end
		end
	endgenerate

	always_comb begin
		case (bus.addr)
			REG_RUN_CLOCK_CONFIG: rmux = run_clock_config;
			REG_RUN_CLOCK_CONFIG_SECOND: rmux = run_clock_config_second;
			REG_RAW_IRQ_STATUS: rmux = {25'h0, lock_raw, 6'h00}; // RULE6
			REG_IRQ_MASK: rmux = imask;
			REG_PLL_XLATE: rmux = {16'h0000, pll_cfg};
			REG_RUN_GATE: rmux = 32'(run_g);
			REG_SLEEP_GATE: rmux = 32'(slp_g);
			REG_DEEP_SLEEP_GATE: rmux = 32'(dp_g);
			REG_DEEP_SLEEP_CLOCK_CFG: rmux = ds_cfg;
			REG_CLOCK_STATE: rmux = {24'h0, mode, sys_clk_run, pll_sel, 1'b0, sys_src};
			default: rmux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus.rdata <= 32'h00000000;
			bus.lock_irq <= 1'b0;
		end else begin
			bus.rdata <= bus.rd ? rmux : 32'h00000000;
			bus.lock_irq <= lock_raw && imask[LOCK_BIT]; // RULE6
		end
	end
endmodule : plcc_clock_ctrl

// >>> design/plcc_core_ctrl.sv
// core side: forwards register accesses, signals sleep, runs the PLL change sequence
// assumes device returns read data the cycle after rd
`timescale 1ns/1ps
module plcc_core_ctrl import plcc_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	plcc_if.core bus,
	input wire logic [3:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [31:0] cmd_rdata
);
	typedef enum logic [2:0] {
		PLCC_H_IDLE = 3'b000,
		PLCC_H_RDW = 3'b001,
		PLCC_H_CFG = 3'b010,
		PLCC_H_DIV = 3'b011,
		PLCC_H_POLL = 3'b100,
		PLCC_H_POLLW = 3'b101,
		PLCC_H_USE = 3'b110
	} plcc_hstate_t;
	plcc_hstate_t st;
	logic [3:0] target;
	logic [31:0] data, shadow, pllt, word;
	logic refused, done, rd_q;
	logic go_wr, go_rd, go_pll;

	assign go_wr = cmd_wr && cmd_addr == H_CMD && cmd_wdata[CMD_WR];
	assign go_rd = cmd_wr && cmd_addr == H_CMD && cmd_wdata[CMD_RD];
	assign go_pll = cmd_wr && cmd_addr == H_CMD && cmd_wdata[CMD_PLL];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			target <= 4'h0;
			pllt <= 32'h00000000;
			bus.deep_en <= 1'b0;
		end else if (cmd_wr) begin
			if (cmd_addr == H_TARGET) target <= cmd_wdata[3:0];
			if (cmd_addr == H_PLL) pllt <= cmd_wdata;
			if (cmd_addr == H_DEEP) bus.deep_en <= cmd_wdata[0]; // RULE15
		end
	end

	// sleep strobes; deep enable is a level already written beforehand
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus.wait_for_interrupt_instr <= 1'b0;
			bus.wake <= 1'b0;
		end else begin
			bus.wait_for_interrupt_instr <= cmd_wr && cmd_addr == H_CMD && cmd_wdata[CMD_WFI]; // RULE15
			bus.wake <= cmd_wr && cmd_addr == H_CMD && cmd_wdata[CMD_WAKE];
		end
	end

	// step words built from the last value written to the first config register
	always_comb begin
		word = shadow;
		case (st)
			PLCC_H_IDLE: begin
				word[BYPASS_BIT] = 1'b1; // RULE17
				word[APPLY_BIT] = 1'b0;
			end
			PLCC_H_CFG: begin
				word[CRYSTAL_SELECT_LO+:4] = pllt[7:4]; // RULE17
				word[OSC_LO+:2] = pllt[1:0];
				word[PWROFF_BIT] = 1'b0;
			end
			PLCC_H_DIV: begin
				word[DIV_LO+:4] = pllt[11:8]; // RULE17
				word[APPLY_BIT] = 1'b1;
			end
			PLCC_H_USE: word[BYPASS_BIT] = 1'b0; // RULE17
			default: ;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= PLCC_H_IDLE;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			bus.addr <= 4'h0;
			bus.wdata <= 32'h00000000;
			shadow <= RCC_RST;
			data <= 32'h00000000;
			refused <= 1'b0;
			done <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			// rdata is launched one edge after rd goes out, so reads wait a cycle
			rd_q <= bus.rd;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			if (cmd_wr && cmd_addr == H_DATA && st == PLCC_H_IDLE) data <= cmd_wdata;
			case (st)
				PLCC_H_IDLE: begin
					if (go_wr) begin
						bus.wr <= 1'b1;
						bus.addr <= target;
						bus.wdata <= data;
						if (target == REG_RUN_CLOCK_CONFIG) shadow <= data;
					end else if (go_rd) begin
						bus.rd <= 1'b1;
						bus.addr <= target;
						st <= PLCC_H_RDW;
					end else if (go_pll) begin
						done <= 1'b0;
						refused <= pllt[1:0] != OSC_MAIN[1:0]; // RULE20
						if (pllt[1:0] == OSC_MAIN[1:0]) begin
							bus.wr <= 1'b1; // RULE17
							bus.addr <= REG_RUN_CLOCK_CONFIG;
							bus.wdata <= word;
							shadow <= word;
							st <= PLCC_H_CFG;
						end
					end
				end
				PLCC_H_RDW: begin
					if (rd_q) begin
						data <= bus.rdata;
						st <= PLCC_H_IDLE;
					end
				end
				PLCC_H_CFG, PLCC_H_DIV, PLCC_H_USE: begin
					bus.wr <= 1'b1;
					bus.addr <= REG_RUN_CLOCK_CONFIG;
					bus.wdata <= word;
					shadow <= word;
					st <= st == PLCC_H_CFG ? PLCC_H_DIV : st == PLCC_H_DIV ? PLCC_H_POLL : PLCC_H_IDLE;
					if (st == PLCC_H_USE) done <= 1'b1;
				end
				PLCC_H_POLL: begin
					bus.rd <= 1'b1; // RULE17
					bus.addr <= REG_RAW_IRQ_STATUS;
					st <= PLCC_H_POLLW;
				end
				PLCC_H_POLLW: begin
					if (rd_q)
						st <= bus.rdata[LOCK_BIT] ? PLCC_H_USE : PLCC_H_POLL; // RULE17
				end
				default: st <= PLCC_H_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			cmd_rdata <= 32'h00000000;
		else if (cmd_rd) begin
			case (cmd_addr)
				H_TARGET: cmd_rdata <= {28'h0, target};
				H_DATA: cmd_rdata <= data;
				H_DEEP: cmd_rdata <= {31'h0, bus.deep_en};
				H_PLL: cmd_rdata <= pllt;
				H_STAT: cmd_rdata <= {28'h0, bus.lock_irq, done, refused, st != PLCC_H_IDLE};
				default: cmd_rdata <= 32'h00000000;
			endcase
		end else
			cmd_rdata <= 32'h00000000;
	end
endmodule : plcc_core_ctrl

// >>> test/plcc_bus_assertions.sv
// interface checker: bus strobes, read data timing, relock and lock reporting
// assumes both ends on ref_clk, rst synchronous active high, relock count shortened
`timescale 1ns/1ps
module plcc_bus_assertions import plcc_pkg::*; #(
	parameter int RELOCK_CYC = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic wait_for_interrupt_instr,
	input wire logic deep_en,
	input wire logic wake,
	input wire logic lock_irq
);
	localparam int LK_MAX = RELOCK_CYC + 4;
	logic [3:0] crystal_select_q;
	logic pw1, pw2, ovr, mask_q, byp_q, xw_q;
	int since;
	wire w0 = wr && addr == 4'h0;
	wire w1 = wr && addr == 4'h1;
	wire ovr_n = w1 ? wdata[OVR_BIT] : ovr;
	wire pw_n = ovr_n ? (w1 ? wdata[PWROFF_BIT] : pw2) : (w0 ? wdata[PWROFF_BIT] : pw1);
	wire trig = (w0 && wdata[9:6] != crystal_select_q) || ((ovr ? pw2 : pw1) && !pw_n);
	// shadow of what the device should hold, kept from the bus alone
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			crystal_select_q <= RCC_RST[9:6];
			{pw1, pw2, ovr, mask_q, byp_q, xw_q} <= 6'b110010;
			since <= LK_MAX + 1;
		end else begin
			if (w0) {crystal_select_q, pw1, byp_q, xw_q} <= {wdata[9:6], wdata[13], wdata[11], 1'b1};
			if (w1) {pw2, ovr} <= {wdata[13], wdata[31]};
			if (wr && addr == 4'h3) mask_q <= wdata[LOCK_BIT];
			if (trig) since <= 0;
			else if (since <= LK_MAX) since <= since + 1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	strobes_apart_a: assert property (!(wr && rd) && !(wait_for_interrupt_instr && wake))
		else $error("strobes overlap");
	rdata_idle_a: assert property (rdata != 32'h0 |-> $past(rd))
		else $error("read data outside its cycle");
	unmapped_read_a: assert property (rd && addr > 4'h9 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	mask_read_a: assert property (rd && addr == 4'h3 |=> rdata[6] == mask_q)
		else $error("mask read wrong");
	xlate_read_a: assert property (rd && addr == 4'h4 && xw_q && !$past(wr) |=>
		rdata[15:0] == (16'h0100 | {8'h00, crystal_select_q, 4'h0}))
		else $error("translation not loaded");
	relock_clear_a: assert property (trig && mask_q |-> ##3 !lock_irq)
		else $error("lock not cleared by relock");
	relock_min_a: assert property ($rose(lock_irq) |-> since >= RELOCK_CYC)
		else $error("lock came early");
	relock_max_a: assert property (since == LK_MAX && mask_q && $past(mask_q) |-> lock_irq)
		else $error("lock came late");
	bypass_first_a: assert property (w0 && !wdata[13] && pw1 |-> byp_q)
		else $error("PLL powered before bypass");
	deep_order_a: assert property (wait_for_interrupt_instr |-> $stable(deep_en))
		else $error("deep enable moved with wait");
	cover property (trig);
	cover property ($rose(lock_irq));
	cover property (wait_for_interrupt_instr && deep_en);
	cover property (rd && addr == 4'h4);
endmodule : plcc_bus_assertions

// >>> test/pll_lock_and_sleep_clock_ctrl_bench.sv
// self-checking bench: core sequencer and clock controller joined by plcc_if
// assumes 40 MHz ref_clk and relock count shortened to 16
`timescale 1ns/1ps
module pll_lock_and_sleep_clock_ctrl_bench import plcc_pkg::*; ;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] cmd_addr = 4'h0;
	logic [31:0] cmd_wdata = 32'h0;
	logic cmd_wr = 1'b0, cmd_rd = 1'b0, rd_chk = 1'b0, p1 = 1'b0;
	logic [31:0] cmd_rdata, rv, rc, run_g, slp_g, dp_g, periph_clk_en;
	logic cpu_clk_en, mem_clk_en, sys_clk_run, pll_sel, pll_prediv, div_en;
	logic pll_pwr, mosc_pwr, int_osc_pwr;
	logic [2:0] sys_src;
	logic [5:0] sys_div;
	logic [15:0] pll_cfg;
	logic [3:0] xt, dv;
	plcc_mode_t mode;
	int n_fail = 0, n_checks = 0, i;
	integer seed = 32'h6d92;
	typedef struct {string nm; logic [31:0] e; logic [31:0] m;} plcc_note_t;
	plcc_note_t notes[$];
	plcc_if bus_if();
	plcc_clock_ctrl #(.NP(32), .RELOCK_CYC(16'h0010)) u_plcc_clock_ctrl (.ref_clk(ref_clk),
		.rst(rst), .bus(bus_if.dev), .cpu_clk_en(cpu_clk_en), .mem_clk_en(mem_clk_en),
		.periph_clk_en(periph_clk_en), .sys_clk_run(sys_clk_run), .sys_src(sys_src),
		.pll_sel(pll_sel), .pll_prediv(pll_prediv), .sys_div(sys_div), .div_en(div_en),
		.pll_pwr(pll_pwr), .mosc_pwr(mosc_pwr), .int_osc_pwr(int_osc_pwr), .pll_cfg(pll_cfg),
		.mode(mode));
	plcc_core_ctrl u_plcc_core_ctrl (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.core),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_rdata(cmd_rdata));
	plcc_bus_assertions #(.RELOCK_CYC(16)) u_chk (.ref_clk(ref_clk), .rst(rst),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .wr(bus_if.wr),
		.rd(bus_if.rd), .wait_for_interrupt_instr(bus_if.wait_for_interrupt_instr), .deep_en(bus_if.deep_en), .wake(bus_if.wake),
		.lock_irq(bus_if.lock_irq));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic hw(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{cmd_wr, cmd_addr, cmd_wdata} <= {1'b1, a, d};
		@(posedge ref_clk);
		cmd_wr <= 1'b0;
	endtask : hw
	task automatic hr(input logic [3:0] a, input logic chk);
		@(posedge ref_clk);
		{cmd_rd, rd_chk, cmd_addr} <= {1'b1, chk, a};
		@(posedge ref_clk);
		cmd_rd <= 1'b0;
		#1 rv = cmd_rdata;
	endtask : hr
	task automatic hr_chk(input logic [3:0] a, input string nm, input logic [31:0] e,
		input logic [31:0] m);
		notes.push_back('{nm, e, m});
		hr(a, 1'b1);
	endtask : hr_chk
	// sequencer status is polled, never waited on blindly
	task automatic stat_wait(input int b, input logic v, input int n);
		for (int k = 0; k < n; k++) begin
			hr(H_STAT, 1'b0);
			if (rv[b] === v) break;
		end
		if (rv[b] !== v) cmp("status bit", 32'(v), 32'(rv[b]));
	endtask : stat_wait
	task automatic dev_wr(input logic [3:0] idx, input logic [31:0] v);
		hw(H_TARGET, 32'(idx));
		hw(H_DATA, v);
		hw(H_CMD, 32'h1);
		stat_wait(0, 1'b0, 40);
	endtask : dev_wr
	task automatic dev_rd(input logic [3:0] idx, input string nm, input logic [31:0] e,
		input logic [31:0] m);
		hw(H_TARGET, 32'(idx));
		hw(H_CMD, 32'h2);
		stat_wait(0, 1'b0, 40);
		hr_chk(H_DATA, nm, e, m);
	endtask : dev_rd
	// read data stand only in the cycle after the strobe, so compare there
	always @(posedge ref_clk) begin
		p1 <= cmd_rd && rd_chk;
		if (p1 && notes.size() == 0) cmp("note queue", 32'h1, 32'h0);
		else if (p1) begin
			cmp(notes[0].nm, notes[0].e, cmd_rdata & notes[0].m);
			void'(notes.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		give_verdict;
	end
	initial begin
		run_g = $random(seed);
		slp_g = $random(seed);
		dp_g = $random(seed);
		xt = 4'($random(seed)) & 4'h7;
		dv = 4'h3 + (4'($random(seed)) & 4'h7);
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(10);
		dev_rd(REG_RUN_CLOCK_CONFIG, "first config", RCC_RST, '1);
		dev_rd(REG_RUN_CLOCK_CONFIG_SECOND, "second config", RUN_CLOCK_CONFIG_SECOND_RST, '1);
		dev_rd(REG_DEEP_SLEEP_CLOCK_CFG, "deep config", DSCFG_RST, '1);
		for (i = 5; i < 8; i++) dev_rd(4'(i), "gate reset", GATE_RST, '1);
		dev_rd(4'hA, "unmapped", 32'h0, '1);
		dev_wr(REG_IRQ_MASK, 32'h40);
		dev_rd(REG_IRQ_MASK, "mask", 32'h40, 32'h40);
		dev_wr(REG_RUN_GATE, run_g);
		dev_wr(REG_SLEEP_GATE, slp_g);
		dev_wr(REG_DEEP_SLEEP_GATE, dp_g);
		cmp("run gates", run_g, periph_clk_en);
		cmp("core clock", 32'h1, 32'(cpu_clk_en));
		hw(H_PLL, {20'h0, dv, xt, 4'h0});
		hw(H_CMD, 32'h10);
		stat_wait(2, 1'b1, 200);
		// the last sequencer write still has to pass the switch gap
		cyc(6);
		cmp("pll source", 32'h1, 32'(pll_sel));
		cmp("divider use", 32'h3, 32'({div_en, sys_clk_run}));
		cmp("predivide", 32'h1, 32'(pll_prediv));
		cmp("divider", 32'(dv), 32'(sys_div));
		cmp("pll power", 32'h1, 32'(pll_pwr));
		cmp("translation", 32'h100 | 32'({xt, 4'h0}), 32'(pll_cfg));
		dev_rd(REG_RAW_IRQ_STATUS, "lock flag", 32'h40, 32'h40);
		dev_rd(REG_PLL_XLATE, "translation reg", 32'h100 | 32'({xt, 4'h0}), '1);
		rc = 32'h08400000 | {5'h0, dv, 23'h0} | {22'h0, xt, 6'h0};
		dev_wr(REG_RUN_CLOCK_CONFIG, rc);
		hw(H_DEEP, 32'h0);
		hw(H_CMD, 32'h4);
		cyc(4);
		cmp("sleep mode", 32'(PLCC_SLEEP), 32'(mode));
		cmp("core off", 32'h0, 32'({cpu_clk_en, mem_clk_en}));
		cmp("sleep gates", slp_g, periph_clk_en);
		cmp("sleep clock", {1'b1, dv}, 32'({pll_sel, sys_div[3:0]}));
		hw(H_CMD, 32'h8);
		cyc(4);
		cmp("run again", run_g, periph_clk_en);
		dev_wr(REG_DEEP_SLEEP_CLOCK_CFG, 32'h12800010);
		hw(H_DEEP, 32'h1);
		hw(H_CMD, 32'h4);
		cyc(8);
		cmp("deep mode", 32'(PLCC_DEEP), 32'(mode));
		cmp("deep gates", dp_g, periph_clk_en);
		cmp("deep osc", {OSC_INT, 2'b10}, 32'({sys_src, int_osc_pwr, mosc_pwr}));
		cmp("deep pll", 32'h0F, 32'({pll_pwr, pll_sel, sys_div}));
		hw(H_DEEP, 32'h0);
		hw(H_CMD, 32'h8);
		for (i = 0; i < 200 && cpu_clk_en !== 1'b1; i++) cyc(1);
		// the clock must be back on the PLL by the time the core restarts
		cmp("wake clock", {1'b1, dv}, 32'({pll_sel, sys_div[3:0]}));
		cmp("wake mode", 32'(PLCC_RUN), 32'(mode));
		dev_wr(REG_RUN_CLOCK_CONFIG, rc);
		cyc(4);
		cmp("same crystal", 32'h1, 32'(bus_if.lock_irq));
		dev_wr(REG_RUN_CLOCK_CONFIG, rc ^ 32'h200);
		cyc(2);
		cmp("relock start", 32'h0, 32'(bus_if.lock_irq));
		cyc(30);
		cmp("relock end", 32'h1, 32'(bus_if.lock_irq));
		cmp("new translation", 32'h100 | 32'({xt ^ 4'h8, 4'h0}), 32'(pll_cfg));
		hw(H_PLL, 32'h1);
		hw(H_CMD, 32'h10);
		stat_wait(0, 1'b0, 40);
		hr_chk(H_STAT, "refused", 32'h2, 32'h2);
		dev_wr(REG_RUN_CLOCK_CONFIG_SECOND, 32'h87802820);
		cyc(10);
		cmp("override source", 32'(OSC_INT4), 32'(sys_src));
		cmp("pll off", 32'h0, 32'({pll_pwr, pll_sel}));
		cyc(4);
		give_verdict;
	end
endmodule : pll_lock_and_sleep_clock_ctrl_bench
